// file: hdl/cid_defines.vh
`ifndef CID_DEFINES_VH
`define CID_DEFINES_VH

// ***************************************************************
// instruction fields
// ***************************************************************
`define CID_F_RD      2:0
`define CID_F_RS      5:3
`define CID_F_SHAMT   10:6
`define CID_F_RN      8:6
`define CID_F_IMMSEL  10
`define CID_F_SUBOP   9
`define CID_F_RD8     10:8
`define CID_F_IMM8    7:0
`define CID_F_OP2     12:11
`define CID_F_OP4     9:6
`define CID_F_TOP3    15:13
`define CID_F_TOP5    15:11
`define CID_F_TOP6    15:10

// ***************************************************************
// format signatures
// ***************************************************************
`define CID_SIG_SHIFT 3'h0
`define CID_SIG_ADDSUB 5'h03
`define CID_SIG_IMM8  3'h1
`define CID_SIG_ALU   6'h10

// ***************************************************************
// two-bit opcodes
// ***************************************************************
`define CID_SH_LSL    2'h0
`define CID_SH_LSR    2'h1
`define CID_SH_ASR    2'h2
`define CID_SH_ROR    2'h3
`define CID_I8_MOV    2'h0
`define CID_I8_CMP    2'h1
`define CID_I8_ADD    2'h2
`define CID_I8_SUB    2'h3

// ***************************************************************
// register-pair alu opcodes
// ***************************************************************
`define CID_A_AND     4'h0
`define CID_A_XOR     4'h1
`define CID_A_LSL     4'h2
`define CID_A_LSR     4'h3
`define CID_A_ASR     4'h4
`define CID_A_ADC     4'h5
`define CID_A_SBC     4'h6
`define CID_A_ROR     4'h7
`define CID_A_TST     4'h8
`define CID_A_NEG     4'h9
`define CID_A_CMP     4'hA
`define CID_A_CMN     4'hB
`define CID_A_ORR     4'hC
`define CID_A_MUL     4'hD
`define CID_A_BIC     4'hE
`define CID_A_MVN     4'hF

// ***************************************************************
// flags, reset values, shift wrap amount, cycle counts
// ***************************************************************
`define CID_FLAG_N    3
`define CID_FLAG_Z    2
`define CID_FLAG_C    1
`define CID_FLAG_V    0
`define CID_FLAGS_RST 4'h0
`define CID_SH_WRAP   8'h20
`define CID_CYC_BASE  3'h1
`define CID_CYC_RSH   3'h2

`endif

// file: hdl/cid_core.v
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.vh"

// Overview of operation
// - shift-immediate op 00 shifts left
// - shift-immediate op 01 logical right shift
// - shift-immediate op 10 arithmetic right shift
// - fields: dest 2:0, src 5:3, amount 10:6
// - every instruction here updates the flags
// - add register to source register
// - add 3-bit immediate to source
// - subtract register from source register
// - subtract 3-bit immediate from source
// - byte immediate 7:0, register 10:8
// - op 00 loads zero-extended byte
// - op 01 compares, flags only
// - op 10 adds byte into register
// - op 11 subtracts byte from register
// - bitwise ops and, xor, or, bic, mvn
// - register-amount shifts and rotate
// - add with carry, subtract with borrow
// - and-test sets flags only
// - compares by subtraction/addition, flags only
// - negate writes zero minus source
// - multiply writes product, sets flags
// - cycles equal the wide-form equivalent
module cid_core (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        instr_valid,
    input  wire [15:0] instr_word,
    output wire        instr_ready,
    output wire [2:0]  rf_rd_a_idx,
    input  wire [31:0] rf_rd_a_data,
    output wire [2:0]  rf_rd_b_idx,
    input  wire [31:0] rf_rd_b_data,
    output reg         rf_wr_en_q,
    output reg  [2:0]  rf_wr_idx_q,
    output reg  [31:0] rf_wr_data_q,
    output reg  [3:0]  status_flags_register,
    output reg         exec_done_q,
    output reg         unsupported_q
);

    // ***************************************************************
    // state and sequencing
    // ***************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg        state_q;   // idle or executing
    reg [15:0] inst_q;    // instruction being executed
    reg [2:0]  cyc_q;     // cycles spent so far

    // format recognition on the executing word
    wire is_f2 = (inst_q[`CID_F_TOP5] == `CID_SIG_ADDSUB);
    wire is_f1 = (inst_q[`CID_F_TOP3] == `CID_SIG_SHIFT) && !is_f2;
    wire is_f3 = (inst_q[`CID_F_TOP3] == `CID_SIG_IMM8);
    wire is_f4 = (inst_q[`CID_F_TOP6] == `CID_SIG_ALU);

    // format recognition on the offered word
    wire new_ok = (instr_word[`CID_F_TOP3] == `CID_SIG_SHIFT) ||
                  (instr_word[`CID_F_TOP3] == `CID_SIG_IMM8) ||
                  (instr_word[`CID_F_TOP6] == `CID_SIG_ALU);

    wire [1:0] op2 = inst_q[`CID_F_OP2];
    wire [3:0] op4 = inst_q[`CID_F_OP4];

    // ***************************************************************
    // operand fetch with write bypass
    // ***************************************************************
    // shift field split
    assign rf_rd_a_idx = is_f3 ? inst_q[`CID_F_RD8] :
                         is_f4 ? inst_q[`CID_F_RD] : inst_q[`CID_F_RS];
    assign rf_rd_b_idx = is_f4 ? inst_q[`CID_F_RS] : inst_q[`CID_F_RN];

    // bypass: the previous result lands in the file one edge late
    wire [31:0] opa = (rf_wr_en_q && rf_wr_idx_q == rf_rd_a_idx) ?
                      rf_wr_data_q : rf_rd_a_data;
    wire [31:0] opb = (rf_wr_en_q && rf_wr_idx_q == rf_rd_b_idx) ?
                      rf_wr_data_q : rf_rd_b_data;

    wire [2:0] dst_idx = is_f3 ? inst_q[`CID_F_RD8] : inst_q[`CID_F_RD];
    wire       c_in    = status_flags_register[`CID_FLAG_C];
    wire       v_in    = status_flags_register[`CID_FLAG_V];

    // ***************************************************************
    // cycle count per instruction
    // ***************************************************************
    reg [2:0] need;       // total cycles this instruction takes
    wire mul_1 = (&opa[31:8])  || ~(|opa[31:8]);
    wire mul_2 = (&opa[31:16]) || ~(|opa[31:16]);
    wire mul_3 = (&opa[31:24]) || ~(|opa[31:24]);

    always @* begin
        need = `CID_CYC_BASE;
        if (is_f4) begin
            case (op4)
                // register-specified shifts add one internal cycle
                `CID_A_LSL, `CID_A_LSR, `CID_A_ASR, `CID_A_ROR: need = `CID_CYC_RSH;
                // multiply terminates early on small multipliers
                `CID_A_MUL: need = mul_1 ? `CID_CYC_BASE + 3'h1 :
                                   mul_2 ? `CID_CYC_BASE + 3'h2 :
                                   mul_3 ? `CID_CYC_BASE + 3'h3 :
                                           `CID_CYC_BASE + 3'h4;
                default: need = `CID_CYC_BASE;
            endcase
        end
    end

    wire last = (state_q == ST_EXEC) && (cyc_q == need);
    // accept in the last cycle so single-cycle ops run back to back
    assign instr_ready = (state_q == ST_IDLE) || last;
    wire take = instr_valid && instr_ready;

    // ***************************************************************
    // operation decode
    // ***************************************************************
    localparam SEL_ADD = 2'h0;
    localparam SEL_SH  = 2'h1;
    localparam SEL_LOG = 2'h2;
    localparam SEL_MUL = 2'h3;

    reg [1:0]  sel;       // which unit feeds the result
    reg        wr_d;      // result goes back to the file
    reg [31:0] add_a;     // adder operands
    reg [31:0] add_b;
    reg        add_ci;
    reg [31:0] sh_val;    // shifter operands
    reg [7:0]  sh_amt;
    reg [1:0]  sh_kind;
    reg [31:0] log_res;   // bitwise result

    always @* begin
        sel     = SEL_LOG;
        wr_d    = 1'b1;
        add_a   = opa;
        add_b   = opb;
        add_ci  = 1'b0;
        sh_val  = opa;
        sh_amt  = {3'h0, inst_q[`CID_F_SHAMT]};
        sh_kind = op2;
        log_res = opa;
        if (is_f2) begin
            sel = SEL_ADD;
            if (inst_q[`CID_F_IMMSEL]) begin
                add_b = {29'h0000_0000, inst_q[`CID_F_RN]};
            end
            if (inst_q[`CID_F_SUBOP]) begin
                add_b  = ~add_b;
                add_ci = 1'b1;
            end
        end else if (is_f1) begin
            sel = SEL_SH;
            if (op2 != `CID_SH_LSL && inst_q[`CID_F_SHAMT] == 5'h00)
                sh_amt = `CID_SH_WRAP;
        end else if (is_f3) begin
            add_b = {24'h00_0000, inst_q[`CID_F_IMM8]};
            case (op2)
                `CID_I8_MOV: log_res = add_b;
                `CID_I8_CMP: begin
                    sel    = SEL_ADD;
                    wr_d   = 1'b0;
                    add_b  = ~add_b;
                    add_ci = 1'b1;
                end
                `CID_I8_ADD: sel = SEL_ADD;
                default: begin
                    sel    = SEL_ADD;
                    add_b  = ~add_b;
                    add_ci = 1'b1;
                end
            endcase
        end else begin
            sh_amt = opb[7:0];
            case (op4)
                `CID_A_AND: log_res = opa & opb;
                `CID_A_XOR: log_res = opa ^ opb;
                `CID_A_ORR: log_res = opa | opb;
                `CID_A_BIC: log_res = opa & ~opb;
                `CID_A_MVN: log_res = ~opb;
                `CID_A_LSL: begin
                    sel     = SEL_SH;
                    sh_kind = `CID_SH_LSL;
                end
                `CID_A_LSR: begin
                    sel     = SEL_SH;
                    sh_kind = `CID_SH_LSR;
                end
                `CID_A_ASR: begin
                    sel     = SEL_SH;
                    sh_kind = `CID_SH_ASR;
                end
                `CID_A_ROR: begin
                    sel     = SEL_SH;
                    sh_kind = `CID_SH_ROR;
                end
                `CID_A_ADC: begin
                    sel    = SEL_ADD;
                    add_ci = c_in;
                end
                `CID_A_SBC: begin
                    sel    = SEL_ADD;
                    add_b  = ~opb;
                    add_ci = c_in;
                end
                `CID_A_TST: begin
                    log_res = opa & opb;
                    wr_d    = 1'b0;
                end
                `CID_A_NEG: begin
                    sel    = SEL_ADD;
                    add_a  = 32'h0000_0000;
                    add_b  = ~opb;
                    add_ci = 1'b1;
                end
                `CID_A_CMP: begin
                    sel    = SEL_ADD;
                    wr_d   = 1'b0;
                    add_b  = ~opb;
                    add_ci = 1'b1;
                end
                `CID_A_CMN: begin
                    sel  = SEL_ADD;
                    wr_d = 1'b0;
                end
                `CID_A_MUL: sel = SEL_MUL;
                default: log_res = opa;
            endcase
        end
    end

    // ***************************************************************
    // arithmetic units
    // ***************************************************************
    // one adder serves every add, subtract and compare
    wire [32:0] sum = {1'b0, add_a} + {1'b0, add_b} +
                      {32'h0000_0000, add_ci};
    wire add_v = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);

    // 33-bit shifts leave the last bit out in the spare position
    wire [32:0] lsl_w = {1'b0, sh_val} << sh_amt;
    wire [32:0] lsr_w = {sh_val, 1'b0} >> sh_amt;
    wire [32:0] asr_w = $signed({sh_val, 1'b0}) >>> sh_amt;
    wire [63:0] ror_w = {sh_val, sh_val} >> sh_amt[4:0];

    reg [31:0] sh_res;    // shifter result
    reg        sh_c;      // shifter carry out

    always @* begin
        case (sh_kind)
            `CID_SH_LSL: begin
                sh_res = lsl_w[31:0];
                sh_c   = lsl_w[32];
            end
            `CID_SH_LSR: begin
                sh_res = lsr_w[32:1];
                sh_c   = lsr_w[0];
            end
            `CID_SH_ASR: begin
                sh_res = asr_w[32:1];
                sh_c   = asr_w[0];
            end
            default: begin
                sh_res = ror_w[31:0];
                sh_c   = ror_w[31];
            end
        endcase
    end

    // low word of the product is all that is kept
    wire [63:0] prod = opa * opb;

    // ***************************************************************
    // result and flag selection
    // ***************************************************************
    reg [31:0] res;       // value to write back
    reg        nc;        // next carry
    reg        nv;        // next overflow

    always @* begin
        res = log_res;
        nc  = c_in;
        nv  = v_in;
        case (sel)
            SEL_ADD: begin
                res = sum[31:0];
                nc  = sum[32];
                nv  = add_v;
            end
            SEL_SH: begin
                res = sh_res;
                // a zero amount leaves the carry untouched
                if (sh_amt != 8'h00)
                    nc = sh_c;
            end
            // multiply leaves carry and overflow as they were
            SEL_MUL: res = prod[31:0];
            default: res = log_res;
        endcase
    end

    // ***************************************************************
    // sequencing and commit
    // ***************************************************************
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_q               <= ST_IDLE;
            inst_q                <= 16'h0000;
            cyc_q                 <= 3'h0;
            rf_wr_en_q            <= 1'b0;
            rf_wr_idx_q           <= 3'h0;
            rf_wr_data_q          <= 32'h0000_0000;
            status_flags_register <= `CID_FLAGS_RST;
            exec_done_q           <= 1'b0;
            unsupported_q         <= 1'b0;
        end else begin
            rf_wr_en_q    <= 1'b0;
            exec_done_q   <= 1'b0;
            unsupported_q <= take && !new_ok;
            // commit in the final cycle of the instruction
            if (last) begin
                rf_wr_en_q   <= wr_d;
                rf_wr_idx_q  <= dst_idx;
                rf_wr_data_q <= res;
                exec_done_q  <= 1'b1;
                status_flags_register <= {res[31], res == 32'h0000_0000, nc, nv};
            end
            // words outside these formats are consumed and flagged
            if (take && new_ok) begin
                state_q <= ST_EXEC;
                inst_q  <= instr_word;
                cyc_q   <= `CID_CYC_BASE;
            end else if (last) begin
                state_q <= ST_IDLE;
            end else if (state_q == ST_EXEC) begin
                // hold until the count is reached
                cyc_q <= cyc_q + 3'h1;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/cid_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// low bank register file seen by the decoder
// ************************************************
module cid_rf_model (
    input  wire logic        core_clk,
    input  wire logic [2:0]  rd_a_idx,
    output logic      [31:0] rd_a_data,
    input  wire logic [2:0]  rd_b_idx,
    output logic      [31:0] rd_b_data,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [31:0] wr_data
);
    logic [31:0] regs_q [8];  // eight low bank words, preloaded by the bench
    // reads are combinational, the decoder samples them in its exec cycles
    assign rd_a_data = regs_q[rd_a_idx];
    assign rd_b_data = regs_q[rd_b_idx];
    // one write per edge; a pending write is invisible until this edge
    always @(posedge core_clk) begin
        if (wr_en) begin
            regs_q[wr_idx] <= wr_data;
        end
    end
endmodule
`default_nettype wire

// file: tb/cid_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// decoder result and timing checks
// ************************************************
module cid_core_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        instr_ready,
    input wire logic [2:0]  rf_rd_a_idx,
    input wire logic [31:0] rf_rd_a_data,
    input wire logic [2:0]  rf_rd_b_idx,
    input wire logic [31:0] rf_rd_b_data,
    input wire logic        rf_wr_en_q,
    input wire logic [2:0]  rf_wr_idx_q,
    input wire logic [31:0] rf_wr_data_q,
    input wire logic [3:0]  status_flags_register,
    input wire logic        exec_done_q,
    input wire logic        unsupported_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic take = instr_valid && instr_ready;  // word accepted this edge
    wire logic alien = instr_word[15:14] != 2'h0 && instr_word[15:10] != 6'h10;
    // ************************************************
    // named takes per format
    // ************************************************
    sequence s_shift;
        take && instr_word[15:13] == 3'h0 && instr_word[12:11] != 2'h3;
    endsequence
    sequence s_addsub;
        take && instr_word[15:11] == 5'h03;
    endsequence
    // register add with no write in flight, so file data is current
    sequence s_add_clean;
        take && instr_word[15:9] == 7'h0C ##1 !rf_wr_en_q;
    endsequence
    sequence s_mvn_clean;
        take && instr_word[15:6] == 10'h10F ##1 !rf_wr_en_q;
    endsequence
    a_shift_write: assert property (s_shift |-> ##2 exec_done_q && rf_wr_en_q &&
        rf_wr_idx_q == $past(instr_word[2:0], 2)) else $error("shift write wrong");
    a_addsub_write: assert property (s_addsub |-> ##2 rf_wr_en_q &&
        rf_wr_idx_q == $past(instr_word[2:0], 2)) else $error("add/sub write wrong");
    a_add_value: assert property (s_add_clean |-> ##1
        rf_wr_data_q == $past(rf_rd_a_data) + $past(rf_rd_b_data)) else $error("add sum wrong");
    a_mov_byte: assert property (take && instr_word[15:11] == 5'h04 |-> ##2
        rf_wr_idx_q == $past(instr_word[10:8], 2) &&
        rf_wr_data_q == {24'h00_0000, $past(instr_word[7:0], 2)}) else $error("byte move wrong");
    a_cmp_nowrite: assert property (take && instr_word[15:11] == 5'h05 |-> ##2
        exec_done_q && !rf_wr_en_q) else $error("compare wrote a register");
    a_flag_only: assert property (take &&
        instr_word[15:6] inside {10'h108, 10'h10A, 10'h10B} |-> ##2 exec_done_q && !rf_wr_en_q)
        else $error("flag-only op wrote a register");
    a_regshift_len: assert property (take &&
        instr_word[15:6] inside {10'h102, 10'h103, 10'h104, 10'h107} |->
        ##1 !instr_ready ##1 !exec_done_q ##1 exec_done_q &&
        rf_wr_idx_q == $past(instr_word[2:0], 3)) else $error("register shift timing wrong");
    a_mvn_value: assert property (s_mvn_clean |-> ##1
        rf_wr_data_q == ~$past(rf_rd_b_data)) else $error("inverted move wrong");
    a_alien_pulse: assert property (take && alien |-> ##1 unsupported_q)
        else $error("foreign word not flagged");
    a_alien_cause: assert property (unsupported_q |-> $past(take && alien))
        else $error("spurious unsupported pulse");
    a_flags_nz: assert property (exec_done_q && rf_wr_en_q |->
        status_flags_register[3:2] == {rf_wr_data_q[31], rf_wr_data_q == 32'h0000_0000})
        else $error("n or z flag disagrees with result");
    a_write_done: assert property (rf_wr_en_q |-> exec_done_q)
        else $error("write without commit");
endmodule
bind cid_core cid_core_sva i_cid_core_sva (.core_clk, .rst_n, .instr_valid, .instr_word,
    .instr_ready, .rf_rd_a_idx, .rf_rd_a_data, .rf_rd_b_idx, .rf_rd_b_data, .rf_wr_en_q,
    .rf_wr_idx_q, .rf_wr_data_q, .status_flags_register, .exec_done_q, .unsupported_q);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk;
    logic        rst_n;
    logic        instr_valid;
    logic [15:0] instr_word;
    wire         instr_ready;
    wire  [2:0]  a_idx;
    wire  [31:0] a_data;
    wire  [2:0]  b_idx;
    wire  [31:0] b_data;
    wire         rf_wr_en_q;
    wire  [2:0]  rf_wr_idx_q;
    wire  [31:0] rf_wr_data_q;
    wire  [3:0]  status_flags_register;
    wire         exec_done_q;
    wire         unsupported_q;
    logic [31:0] rv [8];     // register image loaded before each word issued through t
    int          checked   = 0;
    int          bad_count = 0;
    int          cycles    = 0;
    cid_core i_cid_core (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .rf_rd_a_idx(a_idx),
        .rf_rd_a_data(a_data), .rf_rd_b_idx(b_idx), .rf_rd_b_data(b_data),
        .rf_wr_en_q(rf_wr_en_q), .rf_wr_idx_q(rf_wr_idx_q), .rf_wr_data_q(rf_wr_data_q),
        .status_flags_register(status_flags_register), .exec_done_q(exec_done_q),
        .unsupported_q(unsupported_q));
    cid_rf_model i_cid_rf_model (.core_clk(core_clk), .rd_a_idx(a_idx), .rd_a_data(a_data),
        .rd_b_idx(b_idx), .rd_b_data(b_data), .wr_en(rf_wr_en_q), .wr_idx(rf_wr_idx_q),
        .wr_data(rf_wr_data_q));
    // ************************************************
    // clock and hang guard
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ceiling well above the hundred or so cycles the sequence needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ************************************************
    // word builders and access tasks
    // ************************************************
    function automatic logic [15:0] f1(input logic [1:0] o, input logic [4:0] a,
                                       input logic [2:0] s, d);
        return {3'h0, o, a, s, d};
    endfunction
    function automatic logic [15:0] f2(input logic i, o, input logic [2:0] n, s, d);
        return {5'h03, i, o, n, s, d};
    endfunction
    function automatic logic [15:0] f3(input logic [1:0] o, input logic [2:0] d,
                                       input logic [7:0] m);
        return {3'h1, o, d, m};
    endfunction
    function automatic logic [15:0] f4(input logic [3:0] o, input logic [2:0] s, d);
        return {6'h10, o, s, d};
    endfunction
    task automatic chk(input string nm, input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // issue one word on a fresh register image, wait for its commit or unsupported pulse, compare
    task automatic t(input logic [15:0] w, input logic wr, input logic [2:0] ix,
                     input logic [31:0] dv, input logic [3:0] fl, fm, input int cyc);
        int n;
        @(negedge core_clk);
        for (int i = 0; i < 8; i++) i_cid_rf_model.regs_q[i] = rv[i];
        instr_word  = w;
        instr_valid = 1'b1;
        @(posedge core_clk);
        n = 0;
        do begin
            @(negedge core_clk);
            instr_valid = 1'b0;
            n++;
        end while (exec_done_q !== 1'b1 && unsupported_q !== 1'b1 && n < 9);
        chk("cycles", n, cyc);
        chk("write enable", rf_wr_en_q, wr);
        if (wr) begin
            chk("write index", rf_wr_idx_q, ix);
            chk("write data", rf_wr_data_q, dv);
        end
        chk("flags", status_flags_register & fm, fl & fm);
    endtask
    task automatic print_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rst_n       = 1'b0;
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
        rv = '{32'h0000_0005, 32'h8000_0001, 32'h0000_0003, 32'hFFFF_FFFF,
               32'h0000_0001, 32'h0000_00F0, 32'h7FFF_FFFF, 32'h0000_0010};
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        t(f1(2'h0, 5'h01, 3'h1, 3'h0), 1, 3'h0, 32'h0000_0002, 4'h2, 4'hE, 2);
        t(f1(2'h1, 5'h01, 3'h1, 3'h2), 1, 3'h2, 32'h4000_0000, 4'h2, 4'hE, 2);
        t(f1(2'h2, 5'h04, 3'h1, 3'h7), 1, 3'h7, 32'hF800_0000, 4'h8, 4'hE, 2);
        t(f1(2'h1, 5'h00, 3'h1, 3'h2), 1, 3'h2, 32'h0000_0000, 4'h6, 4'hE, 2);
        t(f1(2'h2, 5'h00, 3'h3, 3'h4), 1, 3'h4, 32'hFFFF_FFFF, 4'hA, 4'hE, 2);
        t(f2(1'h0, 1'h0, 3'h4, 3'h3, 3'h0), 1, 3'h0, 32'h0000_0000, 4'h6, 4'hF, 2);
        t(f2(1'h1, 1'h0, 3'h7, 3'h6, 3'h5), 1, 3'h5, 32'h8000_0006, 4'h9, 4'hF, 2);
        t(f2(1'h0, 1'h1, 3'h7, 3'h0, 3'h2), 1, 3'h2, 32'hFFFF_FFF5, 4'h8, 4'hF, 2);
        t(f2(1'h1, 1'h1, 3'h5, 3'h0, 3'h6), 1, 3'h6, 32'h0000_0000, 4'h6, 4'hF, 2);
        t(f3(2'h0, 3'h4, 8'h80), 1, 3'h4, 32'h0000_0080, 4'h0, 4'hC, 2);
        t(f3(2'h1, 3'h2, 8'h03), 0, 3'h0, 32'h0000_0000, 4'h6, 4'hF, 2);
        t(f3(2'h2, 3'h1, 8'hFF), 1, 3'h1, 32'h8000_0100, 4'h8, 4'hF, 2);
        t(f3(2'h3, 3'h7, 8'h20), 1, 3'h7, 32'hFFFF_FFF0, 4'h8, 4'hF, 2);
        t(f4(4'h0, 3'h7, 3'h5), 1, 3'h5, 32'h0000_0010, 4'h0, 4'hC, 2);
        t(f4(4'h1, 3'h1, 3'h3), 1, 3'h3, 32'h7FFF_FFFE, 4'h0, 4'hC, 2);
        t(f4(4'hC, 3'h5, 3'h0), 1, 3'h0, 32'h0000_00F5, 4'h0, 4'hC, 2);
        t(f4(4'hE, 3'h7, 3'h5), 1, 3'h5, 32'h0000_00E0, 4'h0, 4'hC, 2);
        t(f4(4'hF, 3'h3, 3'h0), 1, 3'h0, 32'h0000_0000, 4'h4, 4'hC, 2);
        t(f4(4'h2, 3'h2, 3'h4), 1, 3'h4, 32'h0000_0008, 4'h0, 4'hE, 3);
        t(f4(4'h3, 3'h2, 3'h7), 1, 3'h7, 32'h0000_0002, 4'h0, 4'hE, 3);
        t(f4(4'h4, 3'h2, 3'h1), 1, 3'h1, 32'hF000_0000, 4'h8, 4'hE, 3);
        t(f4(4'h7, 3'h4, 3'h0), 1, 3'h0, 32'h8000_0002, 4'hA, 4'hE, 3);
        t(f4(4'h5, 3'h4, 3'h0), 1, 3'h0, 32'h0000_0007, 4'h0, 4'hF, 2);
        t(f4(4'h6, 3'h4, 3'h0), 1, 3'h0, 32'h0000_0003, 4'h2, 4'hF, 2);
        t(f4(4'h8, 3'h5, 3'h0), 0, 3'h0, 32'h0000_0000, 4'h4, 4'hC, 2);
        t(f4(4'h9, 3'h4, 3'h2), 1, 3'h2, 32'hFFFF_FFFF, 4'h8, 4'hF, 2);
        t(f4(4'hA, 3'h7, 3'h0), 0, 3'h0, 32'h0000_0000, 4'h8, 4'hF, 2);
        t(f4(4'hB, 3'h4, 3'h3), 0, 3'h0, 32'h0000_0000, 4'h6, 4'hF, 2);
        t(f4(4'hD, 3'h7, 3'h0), 1, 3'h0, 32'h0000_0050, 4'h0, 4'hC, 3);
        t(f4(4'hD, 3'h7, 3'h1), 1, 3'h1, 32'h0000_0010, 4'h0, 4'hC, 6);
        t(16'h4700, 0, 3'h0, 32'h0000_0000, 4'h0, 4'h0, 1);
        // back to back: the add must see the move through the bypass
        @(negedge core_clk);
        instr_word  = f3(2'h0, 3'h0, 8'h11);
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_word = f2(1'h0, 1'h0, 3'h0, 3'h0, 3'h1);
        @(negedge core_clk);
        instr_valid = 1'b0;
        chk("first data", rf_wr_data_q, 32'h0000_0011);
        @(negedge core_clk);
        chk("second data", rf_wr_data_q, 32'h0000_0022);
        chk("second index", rf_wr_idx_q, 3'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
